/* File: rtl/serdes_cfg_pkg.sv */
// Package: register map, field layout and carriers for the serdes lane config block
package serdes_cfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0]  MGMT_DEV_ADDR       = 5'h1E;
    localparam logic [15:0] ADDR_HS_TAPS_POL    = 16'h0005;
    localparam logic [15:0] ADDR_LS_LANE_MASK   = 16'h0006;
    localparam logic [15:0] ADDR_LS_LANE_CTRL_B = 16'h0007;
    localparam logic [15:0] ADDR_LS_LANE_CTRL_C = 16'h0008;
    localparam logic [15:0] ADDR_LS_LANE_CHAN   = 16'h000F;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_HS_TAPS_POL     = 16'h2000;
    localparam logic [15:0] RST_LS_LANE_MASK    = 16'hF115;
    localparam logic [15:0] RST_LS_LANE_CTRL_B  = 16'hDC04;
    localparam logic [15:0] RST_LS_LANE_CTRL_C  = 16'h0000;
    localparam logic [15:0] RST_LS_LANE_CHAN    = 16'h0000;
    localparam logic [15:0] RDATA_INVALID       = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RX_SWAP_BIT   = 15;
    localparam int TX_SWAP_BIT   = 14;
    localparam int RSVD_ONE_BIT  = 13;
    localparam int POST1_MSB     = 12;
    localparam int POST1_LSB     = 8;
    localparam int PRE_MSB       = 7;
    localparam int PRE_LSB       = 4;
    localparam int POST2_MSB     = 3;
    localparam int POST2_LSB     = 0;
    localparam int LANE_MASK_MSB = 15;
    localparam int LANE_MASK_LSB = 12;
    localparam int NUM_LANES     = 4;
    localparam int POST1_W       = 5;
    localparam int SHORT_TAP_W   = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic [4:0] post1;
        logic [3:0] pre;
        logic [3:0] post2;
    } tap_codes_t;

endpackage

/* File: rtl/tap_weight_decode.sv */
// Sign-magnitude tap code to two's complement weight in 2.5 percent steps
`timescale 1ns/100ps

module tap_weight_decode #(
    parameter int W = 4
) (
    // Code in
    input  wire logic [W-1:0]        i_code,
    // Signed weight out
    output logic signed [W-1:0]      o_weight
);

    logic [W-1:0] mag;

    // Top bit is the sign, so both zero codes give zero weight
    always_comb begin
        mag      = {1'b0, i_code[W-2:0]};
        o_weight = i_code[W-1] ? -mag : mag;
    end

endmodule

/* File: rtl/serdes_tap_polarity_lane_cfg.sv */
// Transmit tap, pair polarity and low-speed lane configuration registers
`timescale 1ns/100ps

// Notes on behaviour
// R1: A set receive swap bit exchanges the roles of the positive and negative receive pins.
// R2: A set transmit swap bit drives the positive pin with negative data and vice versa.
// R3: Bit 13 of the tap and polarity word is read-write and resets to one.
// R4: The post-cursor one weight resets to zero and is applied from software only under override.
// R5: The pre-cursor weight resets to zero and is applied from software only under override.
// R6: The post-cursor two weight resets to zero and is applied from software only under override.
// R7: Post-cursor one is sign-magnitude with a four-bit magnitude, both zero codes meaning zero.
// R8: Post-cursor two is sign-magnitude with a three-bit magnitude, both zero codes meaning zero.
// R9: Pre-cursor is sign-magnitude with a three-bit magnitude, code 1111 giving the most negative.
// R10: The lane mask is four bits, one per lane, resetting to all ones.
// R11: A write to a per-lane register updates only the lanes whose mask bit is set.
// R12: A per-lane read returns the lane picked by a one-hot mask and is undefined otherwise.
// R13: Software sets a one-hot mask before reads and only the wanted lanes before writes.
// R14: The lane mask register sits at address 0x0006 of device 0x1E and resets to 0xF115.
// R15: Tap fields read back the last software value whatever is applied on the line.
module serdes_tap_polarity_lane_cfg (
    // Clock and reset
    input  wire logic                                i_sys_clk,
    input  wire logic                                i_rst,
    // Management access
    input  wire serdes_cfg_pkg::mgmt_req_t           i_mgmt_req,
    output logic [15:0]                              o_mgmt_rdata,
    output logic                                     o_mgmt_rvalid,
    // Link training taps and override
    input  wire logic                                i_tap_override,
    input  wire serdes_cfg_pkg::tap_codes_t          i_train_taps,
    // High-speed pins and internal data
    input  wire logic                                i_hs_rx_pos_pin,
    input  wire logic                                i_hs_rx_neg_pin,
    input  wire logic                                i_tx_data,
    output logic                                     o_rx_data_pos,
    output logic                                     o_rx_data_neg,
    output logic                                     o_hs_tx_pos_pin,
    output logic                                     o_hs_tx_neg_pin,
    // Applied equalisation
    output serdes_cfg_pkg::tap_codes_t               o_tap_codes,
    output logic signed [4:0]                        o_post1_weight,
    output logic signed [3:0]                        o_pre_weight,
    output logic signed [3:0]                        o_post2_weight,
    // Per-lane low-speed settings
    output logic [serdes_cfg_pkg::NUM_LANES-1:0][15:0] o_lane_ctrl_b,
    output logic [serdes_cfg_pkg::NUM_LANES-1:0][15:0] o_lane_ctrl_c,
    output logic [serdes_cfg_pkg::NUM_LANES-1:0][15:0] o_lane_chan
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic                   dev_hit;
    logic [15:0]            hs_reg_ff;
    logic [15:0]            mask_reg_ff;
    logic [3:0]             lane_mask;
    logic [15:0]            lane_b_ff [serdes_cfg_pkg::NUM_LANES];
    logic [15:0]            lane_c_ff [serdes_cfg_pkg::NUM_LANES];
    logic [15:0]            lane_ch_ff [serdes_cfg_pkg::NUM_LANES];
    serdes_cfg_pkg::tap_codes_t sw_taps;
    serdes_cfg_pkg::tap_codes_t nxt_taps;
    logic signed [4:0]      nxt_post1_w;
    logic signed [3:0]      nxt_pre_w;
    logic signed [3:0]      nxt_post2_w;

    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] ref_a);
        addr_hit = (a == ref_a);
    endfunction

    // Index of a one-hot mask; anything else is reported invalid
    function automatic logic [2:0] onehot_lane(input logic [3:0] m);
        case (m)
            4'h1:    onehot_lane = 3'h0;
            4'h2:    onehot_lane = 3'h1;
            4'h4:    onehot_lane = 3'h2;
            4'h8:    onehot_lane = 3'h3;
            default: onehot_lane = 3'h4;
        endcase
    endfunction

    assign dev_hit   = (i_mgmt_req.dev == serdes_cfg_pkg::MGMT_DEV_ADDR); // R14
    assign lane_mask = mask_reg_ff[serdes_cfg_pkg::LANE_MASK_MSB:serdes_cfg_pkg::LANE_MASK_LSB];

    // ------------------------------------------------------------
    // Shared registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hs_reg_ff <= serdes_cfg_pkg::RST_HS_TAPS_POL; // R3
        end else if (i_mgmt_req.wr && dev_hit
                     && addr_hit(i_mgmt_req.addr, serdes_cfg_pkg::ADDR_HS_TAPS_POL)) begin
            hs_reg_ff <= i_mgmt_req.wdata; // R15
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mask_reg_ff <= serdes_cfg_pkg::RST_LS_LANE_MASK; // R10 R14
        end else if (i_mgmt_req.wr && dev_hit
                     && addr_hit(i_mgmt_req.addr, serdes_cfg_pkg::ADDR_LS_LANE_MASK)) begin
            mask_reg_ff <= i_mgmt_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Per-lane registers
    // ------------------------------------------------------------
    // Mask is trusted as programmed; several lanes may take one write
    for (genvar ln = 0; ln < serdes_cfg_pkg::NUM_LANES; ln++) begin : g_lane
        logic lane_wr;
        assign lane_wr = i_mgmt_req.wr && dev_hit && lane_mask[ln]; // R11 R13
        always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
                lane_b_ff[ln]  <= serdes_cfg_pkg::RST_LS_LANE_CTRL_B;
                lane_c_ff[ln]  <= serdes_cfg_pkg::RST_LS_LANE_CTRL_C;
                lane_ch_ff[ln] <= serdes_cfg_pkg::RST_LS_LANE_CHAN;
            end else if (lane_wr) begin
                if (addr_hit(i_mgmt_req.addr, serdes_cfg_pkg::ADDR_LS_LANE_CTRL_B)) begin
                    lane_b_ff[ln] <= i_mgmt_req.wdata; // R11
                end
                if (addr_hit(i_mgmt_req.addr, serdes_cfg_pkg::ADDR_LS_LANE_CTRL_C)) begin
                    lane_c_ff[ln] <= i_mgmt_req.wdata; // R11
                end
                if (addr_hit(i_mgmt_req.addr, serdes_cfg_pkg::ADDR_LS_LANE_CHAN)) begin
                    lane_ch_ff[ln] <= i_mgmt_req.wdata; // R11
                end
            end
        end
        assign o_lane_ctrl_b[ln] = lane_b_ff[ln];
        assign o_lane_ctrl_c[ln] = lane_c_ff[ln];
        assign o_lane_chan[ln]   = lane_ch_ff[ln];
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_mgmt_rdata  <= 16'h0000;
            o_mgmt_rvalid <= 1'b0;
        end else begin
            o_mgmt_rvalid <= i_mgmt_req.rd;
            if (i_mgmt_req.rd) begin
                o_mgmt_rdata <= serdes_cfg_pkg::RDATA_INVALID;
                if (dev_hit) begin
                    case (i_mgmt_req.addr)
                        serdes_cfg_pkg::ADDR_HS_TAPS_POL:  o_mgmt_rdata <= hs_reg_ff; // R15
                        serdes_cfg_pkg::ADDR_LS_LANE_MASK: o_mgmt_rdata <= mask_reg_ff;
                        serdes_cfg_pkg::ADDR_LS_LANE_CTRL_B: begin
                            if (onehot_lane(lane_mask) < 3'h4) begin
                                o_mgmt_rdata <= lane_b_ff[2'(onehot_lane(lane_mask))]; // R12
                            end
                        end
                        serdes_cfg_pkg::ADDR_LS_LANE_CTRL_C: begin
                            if (onehot_lane(lane_mask) < 3'h4) begin
                                o_mgmt_rdata <= lane_c_ff[2'(onehot_lane(lane_mask))]; // R12
                            end
                        end
                        serdes_cfg_pkg::ADDR_LS_LANE_CHAN: begin
                            if (onehot_lane(lane_mask) < 3'h4) begin
                                o_mgmt_rdata <= lane_ch_ff[2'(onehot_lane(lane_mask))]; // R12
                            end
                        end
                        default: o_mgmt_rdata <= serdes_cfg_pkg::RDATA_INVALID;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Tap selection and weight decode
    // ------------------------------------------------------------
    assign sw_taps.post1 = hs_reg_ff[serdes_cfg_pkg::POST1_MSB:serdes_cfg_pkg::POST1_LSB];
    assign sw_taps.pre   = hs_reg_ff[serdes_cfg_pkg::PRE_MSB:serdes_cfg_pkg::PRE_LSB];
    assign sw_taps.post2 = hs_reg_ff[serdes_cfg_pkg::POST2_MSB:serdes_cfg_pkg::POST2_LSB];
    assign nxt_taps      = i_tap_override ? sw_taps : i_train_taps; // R4 R5 R6

    tap_weight_decode #(.W(serdes_cfg_pkg::POST1_W)) u_post1_dec (
        .i_code   (nxt_taps.post1),
        .o_weight (nxt_post1_w)
    );
    tap_weight_decode #(.W(serdes_cfg_pkg::SHORT_TAP_W)) u_pre_dec (
        .i_code   (nxt_taps.pre),
        .o_weight (nxt_pre_w)
    );
    tap_weight_decode #(.W(serdes_cfg_pkg::SHORT_TAP_W)) u_post2_dec (
        .i_code   (nxt_taps.post2),
        .o_weight (nxt_post2_w)
    );

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_tap_codes    <= '0;
            o_post1_weight <= 5'sh00;
            o_pre_weight   <= 4'sh0;
            o_post2_weight <= 4'sh0;
        end else begin
            o_tap_codes    <= nxt_taps; // R4 R5 R6
            o_post1_weight <= nxt_post1_w; // R7
            o_pre_weight   <= nxt_pre_w; // R9
            o_post2_weight <= nxt_post2_w; // R8
        end
    end

    // ------------------------------------------------------------
    // Pair polarity
    // ------------------------------------------------------------
    // Pins are outside the clock domain: three stages, accept when last two agree
    logic [2:0] rx_pos_sync_ff;
    logic [2:0] rx_neg_sync_ff;
    logic       rx_pos_flt_ff;
    logic       rx_neg_flt_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_pos_sync_ff <= 3'h0;
            rx_neg_sync_ff <= 3'h0;
            rx_pos_flt_ff  <= 1'b0;
            rx_neg_flt_ff  <= 1'b0;
        end else begin
            rx_pos_sync_ff <= {rx_pos_sync_ff[1:0], i_hs_rx_pos_pin};
            rx_neg_sync_ff <= {rx_neg_sync_ff[1:0], i_hs_rx_neg_pin};
            if (rx_pos_sync_ff[1] == rx_pos_sync_ff[2]) begin
                rx_pos_flt_ff <= rx_pos_sync_ff[2];
            end
            if (rx_neg_sync_ff[1] == rx_neg_sync_ff[2]) begin
                rx_neg_flt_ff <= rx_neg_sync_ff[2];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rx_data_pos   <= 1'b0;
            o_rx_data_neg   <= 1'b0;
            o_hs_tx_pos_pin <= 1'b0;
            o_hs_tx_neg_pin <= 1'b1;
        end else begin
            o_rx_data_pos   <= hs_reg_ff[serdes_cfg_pkg::RX_SWAP_BIT] ? rx_neg_flt_ff
                                                                      : rx_pos_flt_ff; // R1
            o_rx_data_neg   <= hs_reg_ff[serdes_cfg_pkg::RX_SWAP_BIT] ? rx_pos_flt_ff
                                                                      : rx_neg_flt_ff; // R1
            o_hs_tx_pos_pin <= i_tx_data ^ hs_reg_ff[serdes_cfg_pkg::TX_SWAP_BIT]; // R2
            o_hs_tx_neg_pin <= ~(i_tx_data ^ hs_reg_ff[serdes_cfg_pkg::TX_SWAP_BIT]); // R2
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rx_swap_map: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R1
        ##1 o_rx_data_pos == ($past(hs_reg_ff[15]) ? $past(rx_neg_flt_ff) : $past(rx_pos_flt_ff)))
        else $error("rx pair swap wrong");
    a_tx_swap_map: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R2
        ##1 (o_hs_tx_pos_pin == ($past(i_tx_data) ^ $past(hs_reg_ff[14])))
            && (o_hs_tx_neg_pin != o_hs_tx_pos_pin))
        else $error("tx pair swap wrong");
    a_hs_reset_val: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R3
        $fell(i_rst) |-> hs_reg_ff == 16'h2000 && hs_reg_ff[13])
        else $error("tap word reset wrong");
    a_override_apply: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R4
        i_tap_override |=> o_tap_codes.post1 == $past(hs_reg_ff[12:8])
                           && o_tap_codes.pre == $past(hs_reg_ff[7:4]))
        else $error("override taps not applied");
    a_training_apply: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R5
        !i_tap_override |=> o_tap_codes == $past(i_train_taps))
        else $error("training taps not applied");
    a_post2_apply: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R6
        i_tap_override |=> o_tap_codes.post2 == $past(hs_reg_ff[3:0]))
        else $error("post2 override not applied");
    a_post1_decode: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R7
        ##1 o_post1_weight == (o_tap_codes.post1[4] ? -$signed({1'b0, o_tap_codes.post1[3:0]})
                                                    : $signed({1'b0, o_tap_codes.post1[3:0]})))
        else $error("post1 weight decode wrong");
    a_post2_decode: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R8
        ##1 (o_tap_codes.post2[2:0] == 3'h0) |-> o_post2_weight == 4'sh0)
        else $error("post2 zero code wrong");
    a_pre_decode: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R9
        ##1 (o_tap_codes.pre == 4'hF) |-> o_pre_weight == -4'sd7)
        else $error("pre most negative wrong");
    a_mask_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R10
        $fell(i_rst) |-> lane_mask == 4'hF && mask_reg_ff == 16'hF115)
        else $error("lane mask reset wrong");
    a_lane_write_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R11
        (i_mgmt_req.wr && dev_hit && i_mgmt_req.addr == 16'h0007)
        |=> lane_b_ff[0] == ($past(lane_mask[0]) ? $past(i_mgmt_req.wdata) : $past(lane_b_ff[0])))
        else $error("lane write mask ignored");
    a_lane_read_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R12
        (i_mgmt_req.rd && dev_hit && i_mgmt_req.addr == 16'h0007 && lane_mask == 4'h8)
        |=> o_mgmt_rvalid && o_mgmt_rdata == $past(lane_b_ff[3]))
        else $error("lane read select wrong");
    a_tap_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R15
        (i_mgmt_req.rd && dev_hit && i_mgmt_req.addr == 16'h0005)
        |=> o_mgmt_rdata == $past(hs_reg_ff))
        else $error("tap readback wrong");

endmodule

/* File: test/tb_serdes_tap_polarity_lane_cfg.sv */
// Self-checking bench for the tap, polarity and lane configuration registers
`timescale 1ns/100ps

module tb_serdes_tap_polarity_lane_cfg;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                                              i_sys_clk;
    logic                                              i_rst;
    serdes_cfg_pkg::mgmt_req_t                         req;
    logic [15:0]                                       o_mgmt_rdata;
    logic                                              o_mgmt_rvalid;
    logic                                              ovr;
    serdes_cfg_pkg::tap_codes_t                        train;
    logic                                              rxp, rxn, txd;
    logic                                              o_rx_data_pos, o_rx_data_neg;
    logic                                              o_hs_tx_pos_pin, o_hs_tx_neg_pin;
    serdes_cfg_pkg::tap_codes_t                        o_tap_codes;
    logic signed [4:0]                                 o_post1_weight;
    logic signed [3:0]                                 o_pre_weight, o_post2_weight;
    logic [serdes_cfg_pkg::NUM_LANES-1:0][15:0]        o_lane_ctrl_b, o_lane_ctrl_c, o_lane_chan;
    int                                                miscompares, num_checks;
    logic [31:0]                                       seed;
    logic [15:0]                                       lm [3][4];
    logic [15:0]                                       lane_addr [3];
    logic [15:0]                                       v, hs;
    logic [3:0]                                        m;
    int                                                r;

    serdes_tap_polarity_lane_cfg u_dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_mgmt_req(req),
        .o_mgmt_rdata(o_mgmt_rdata), .o_mgmt_rvalid(o_mgmt_rvalid),
        .i_tap_override(ovr), .i_train_taps(train),
        .i_hs_rx_pos_pin(rxp), .i_hs_rx_neg_pin(rxn), .i_tx_data(txd),
        .o_rx_data_pos(o_rx_data_pos), .o_rx_data_neg(o_rx_data_neg),
        .o_hs_tx_pos_pin(o_hs_tx_pos_pin), .o_hs_tx_neg_pin(o_hs_tx_neg_pin),
        .o_tap_codes(o_tap_codes), .o_post1_weight(o_post1_weight),
        .o_pre_weight(o_pre_weight), .o_post2_weight(o_post2_weight),
        .o_lane_ctrl_b(o_lane_ctrl_b), .o_lane_ctrl_c(o_lane_ctrl_c), .o_lane_chan(o_lane_chan)
    );

    always #10 i_sys_clk = ~i_sys_clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction

    // Sign-magnitude to two's complement, both zero codes give zero
    function automatic logic [4:0] sm5(input logic [4:0] c);
        return c[4] ? 5'h00 - {1'b0, c[3:0]} : {1'b0, c[3:0]};
    endfunction

    function automatic logic [3:0] sm4(input logic [3:0] c);
        return c[3] ? 4'h0 - {1'b0, c[2:0]} : {1'b0, c[2:0]};
    endfunction

    task automatic report_and_stop();
        $display("Checks: %0d  mismatches: %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic access(input logic is_wr, input logic [4:0] dev, input logic [15:0] addr,
                          input logic [15:0] wdata, output logic [15:0] rdata);
        int i;
        rdata = 16'h0000;
        @(posedge i_sys_clk);
        req <= '{wr: is_wr, rd: !is_wr, dev: dev, addr: addr, wdata: wdata};
        @(posedge i_sys_clk);
        req <= '0;
        if (!is_wr) begin
            i = 0;
            #1;
            while (o_mgmt_rvalid !== 1'b1 && i < 4) begin
                @(posedge i_sys_clk);
                #1;
                i++;
            end
            if (o_mgmt_rvalid !== 1'b1) begin
                miscompares++;
                $display("CHECK FAILED rvalid expected 1 seen %b", o_mgmt_rvalid);
                report_and_stop();
            end
            rdata = o_mgmt_rdata;
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [15:0] d);
        logic [15:0] dummy;
        access(1'b1, serdes_cfg_pkg::MGMT_DEV_ADDR, addr, d, dummy);
    endtask

    task automatic rd(input logic [15:0] addr, output logic [15:0] d);
        access(1'b0, serdes_cfg_pkg::MGMT_DEV_ADDR, addr, 16'h0000, d);
    endtask

    // Select each lane in turn, then read and compare every per-lane register of it
    task automatic check_lanes();
        logic [15:0] d;
        for (int l = 0; l < 4; l++) begin
            wr(serdes_cfg_pkg::ADDR_LS_LANE_MASK, {4'h1 << l, 12'h115});
            for (int k = 0; k < 3; k++) begin
                rd(lane_addr[k], d);
                check("lane read", d, lm[k][l]);
            end
            check("lane b out", o_lane_ctrl_b[l], lm[0][l]);
            check("lane c out", o_lane_ctrl_c[l], lm[1][l]);
            check("lane chan out", o_lane_chan[l], lm[2][l]);
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        i_rst = 1'b1;
        req = '0;
        ovr = 1'b0;
        train = '0;
        rxp = 1'b0;
        rxn = 1'b1;
        txd = 1'b0;
        miscompares = 0;
        num_checks = 0;
        seed = 32'h0000_6233;
        lane_addr = '{serdes_cfg_pkg::ADDR_LS_LANE_CTRL_B, serdes_cfg_pkg::ADDR_LS_LANE_CTRL_C,
                      serdes_cfg_pkg::ADDR_LS_LANE_CHAN};
        for (int l = 0; l < 4; l++) begin
            lm[0][l] = serdes_cfg_pkg::RST_LS_LANE_CTRL_B;
            lm[1][l] = serdes_cfg_pkg::RST_LS_LANE_CTRL_C;
            lm[2][l] = serdes_cfg_pkg::RST_LS_LANE_CHAN;
        end
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        // Reset values
        rd(serdes_cfg_pkg::ADDR_HS_TAPS_POL, v);
        check("hs reset", v, 16'h2000);
        check("taps reset", {3'b000, o_tap_codes}, 16'h0000);
        rd(serdes_cfg_pkg::ADDR_LS_LANE_MASK, v);
        check("mask reset", v, 16'hF115);
        // Unmapped address and foreign device are ignored
        rd(16'h0009, v);
        check("unmapped read", v, 16'h0000);
        access(1'b1, 5'h01, serdes_cfg_pkg::ADDR_HS_TAPS_POL, 16'hFFFF, v);
        rd(serdes_cfg_pkg::ADDR_HS_TAPS_POL, v);
        check("foreign dev write", v, 16'h2000);
        // Taps: negative-zero and extreme codes first, then random
        for (int i = 0; i < 12; i++) begin
            hs = (i == 0) ? 16'h3088 : (i == 1) ? 16'h2FFF : (rnd() & 16'h3FFF) | 16'h2000;
            wr(serdes_cfg_pkg::ADDR_HS_TAPS_POL, hs);
            v = rnd();
            train <= v[12:0];
            ovr <= (i < 2) ? 1'b1 : v[15];
            repeat (3) @(posedge i_sys_clk);
            #1;
            v = ovr ? {3'b000, hs[12:0]} : {3'b000, train};
            check("tap codes", {3'b000, o_tap_codes}, v);
            check("post1 weight", {11'h000, o_post1_weight}, {11'h000, sm5(v[12:8])});
            check("pre weight", {12'h000, o_pre_weight}, {12'h000, sm4(v[7:4])});
            check("post2 weight", {12'h000, o_post2_weight}, {12'h000, sm4(v[3:0])});
            rd(serdes_cfg_pkg::ADDR_HS_TAPS_POL, v);
            check("hs readback", v, hs);
        end
        // Receive and transmit pair swap
        for (int i = 0; i < 8; i++) begin
            wr(serdes_cfg_pkg::ADDR_HS_TAPS_POL, {i[1], i[2], 14'h2000});
            v = rnd();
            rxp <= v[0];
            rxn <= v[1];
            repeat (8) @(posedge i_sys_clk);
            #1;
            check("rx pos", o_rx_data_pos, i[1] ? rxn : rxp);
            check("rx neg", o_rx_data_neg, i[1] ? rxp : rxn);
            @(posedge i_sys_clk);
            txd <= v[2];
            @(posedge i_sys_clk);
            #1;
            check("tx pos", o_hs_tx_pos_pin, v[2] ^ i[2]);
            check("tx neg", o_hs_tx_neg_pin, !(v[2] ^ i[2]));
        end
        // Lane masks: none, two lanes, all, then random
        check_lanes();
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            m = (i == 0) ? 4'h0 : (i == 1) ? 4'h3 : (i == 2) ? 4'hF : v[15:12];
            r = rnd() % 3;
            v = rnd();
            wr(serdes_cfg_pkg::ADDR_LS_LANE_MASK, {m, 12'h115});
            wr(lane_addr[r], v);
            for (int l = 0; l < 4; l++) begin
                if (m[l]) begin
                    lm[r][l] = v;
                end
            end
            check_lanes();
        end
        // Mask with more than one lane reads as invalid
        wr(serdes_cfg_pkg::ADDR_LS_LANE_MASK, 16'h5115);
        rd(serdes_cfg_pkg::ADDR_LS_LANE_MASK, v);
        check("mask readback", v, 16'h5115);
        rd(serdes_cfg_pkg::ADDR_LS_LANE_CTRL_B, v);
        check("multi lane read", v, serdes_cfg_pkg::RDATA_INVALID);
        report_and_stop();
    end
endmodule
